// ---- core/pad_ctrl_pkg.sv ----
package pad_ctrl_pkg;

    // Byte addresses on the register bus
    localparam logic [11:0] CAL_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] PAD_CFG_ADDR    = 12'h004;
    localparam logic [11:0] FUSE_SHADOW_ADDR = 12'h008;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;

    // Calibration control fields
    localparam int          CAL_LOCK_BIT    = 7;
    localparam int          CAL_PDN_BIT     = 6;
    localparam int          CAL_PSAVE_BIT   = 8;
    localparam int          CAL_DRIVE_LSB   = 3;
    localparam int          CAL_FILTER_LSB  = 0;
    localparam int          CAL_VALID_BITS  = 9;
    localparam int          CAL_READY_BIT   = 15;
    localparam logic [1:0]  FUSE_SETTLE     = 2'h2;
    localparam logic        LOCK_RST        = 1'b0;
    localparam logic        PDN_RST         = 1'b1;
    localparam logic        PSAVE_RST       = 1'b0;
    localparam logic [2:0]  DRIVE_RST       = 3'h6;
    localparam logic [2:0]  FILTER_RST      = 3'h7;

    // Pad configuration fields
    localparam int          CFG_RX_BIT      = 4;
    localparam int          CFG_PD_BIT      = 5;
    localparam int          CFG_TERM_ON_LSB = 10;
    localparam int          CFG_TERM_OFF_LSB = 8;
    localparam int          CFG_DSLEW_LSB   = 2;
    localparam int          CFG_CSLEW_LSB   = 0;
    localparam logic [1:0]  CODE_ZERO       = 2'h0;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// ---- core/fuse_shadow.sv ----
`timescale 1ns/1ps
module fuse_shadow
    import pad_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Fuse inputs
    input  wire logic [1:0] fuse_pins,
    // Captured values
    output logic      [1:0] shadow,
    output logic            loaded
);
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] settle;

    // Two-stage synchroniser on fuse pins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
        end
        else
        begin
            sync_a <= fuse_pins;
            sync_b <= sync_a;
        end
    end

    // Capture once, after the synchroniser has filled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shadow <= 2'h0;
            loaded <= 1'b0;
            settle <= 2'h0;
        end
        else if (!loaded)
        begin
            if (settle == FUSE_SETTLE)
            begin
                shadow <= sync_b;
                loaded <= 1'b1;
            end
            else
            begin
                settle <= settle + 2'h1;
            end
        end
    end
endmodule

// ---- core/pad_ctrl_regs.sv ----
// Notes on behaviour
// - Lock bit freezes calibrated impedance
// - Power-down bit stops calibration controller
// - Power save only acts without power-down
// - Pad config shows fuse-loaded settings
// - Bit 4 selects SSTL or LVCMOS receiver
// - Bit 5 enables pad pull-downs
// - Active termination field always zero
// - Idle termination field always zero
// - Data pad slew field always zero
// - Command pad slew field always zero
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module pad_ctrl_regs
    import pad_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Fuse pins
    input  wire logic              fuse_receiver_type,
    input  wire logic              fuse_pulldown,
    // Calibration controller
    input  wire logic              calibration_ready,
    output logic                   impedance_lock,
    output logic                   calibrator_shutdown,
    output logic                   resistor_power_save,
    output logic [2:0]             drive_strength,
    output logic [2:0]             filter_setting,
    // Pad configuration
    output logic                   receiver_type_select,
    output logic                   pad_pulldown_enable
);
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic [1:0]        fuse_shadow_bits;
    logic              fuse_loaded;
    logic              fuse_taken;
    logic              rx_sel;
    logic              pd_en;
    logic              lock_q;
    logic              pdn_q;
    logic              psave_q;
    logic              ready_s1;
    logic              ready_s2;
    logic              do_write;
    logic              wr_cal;
    logic              wr_cfg;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] r);
        addr_is = (a[ADDR_W-1:2] == r[ADDR_W-1:2]);
    endfunction

    fuse_shadow u_fuse
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .fuse_pins ({fuse_pulldown, fuse_receiver_type}),
        .shadow    (fuse_shadow_bits),
        .loaded    (fuse_loaded)
    );

    // Calibration ready synchroniser
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ready_s1 <= 1'b0;
            ready_s2 <= 1'b0;
        end
        else
        begin
            ready_s1 <= calibration_ready;
            ready_s2 <= ready_s1;
        end
    end

    // Write channel capture
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wr_cal        = do_write && addr_is(aw_addr, CAL_CTRL_ADDR);
    assign wr_cfg        = do_write && addr_is(aw_addr, PAD_CFG_ADDR);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (addr_is(aw_addr, CAL_CTRL_ADDR)
                          || addr_is(aw_addr, PAD_CFG_ADDR)
                          || addr_is(aw_addr, FUSE_SHADOW_ADDR))
                          ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Calibration control low byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lock_q         <= LOCK_RST;
            pdn_q          <= PDN_RST;
            drive_strength <= DRIVE_RST;
            filter_setting <= FILTER_RST;
        end
        else if (wr_cal && w_strb[0])
        begin
            lock_q         <= w_data[CAL_LOCK_BIT];
            pdn_q          <= w_data[CAL_PDN_BIT];
            drive_strength <= w_data[CAL_DRIVE_LSB +: 3];
            filter_setting <= w_data[CAL_FILTER_LSB +: 3];
        end
    end

    // Power save bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            psave_q <= PSAVE_RST;
        end
        else if (wr_cal && w_strb[1])
        begin
            psave_q <= w_data[CAL_PSAVE_BIT];
        end
    end

    assign impedance_lock      = lock_q;
    assign calibrator_shutdown = pdn_q;
    assign resistor_power_save = psave_q && !pdn_q;

    // Fuse values applied once, when the shadow is valid
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fuse_taken <= 1'b0;
        end
        else if (fuse_loaded)
        begin
            fuse_taken <= 1'b1;
        end
    end

    // Pad configuration, seeded from fuses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_sel <= 1'b0;
            pd_en  <= 1'b0;
        end
        else if (fuse_loaded && !fuse_taken)
        begin
            rx_sel <= fuse_shadow_bits[0];
            pd_en  <= fuse_shadow_bits[1];
        end
        else if (wr_cfg && w_strb[0])
        begin
            rx_sel <= w_data[CFG_RX_BIT];
            pd_en  <= w_data[CFG_PD_BIT];
        end
    end

    assign receiver_type_select = rx_sel;
    assign pad_pulldown_enable  = pd_en;

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
            if (addr_is(s_axi_araddr, CAL_CTRL_ADDR))
            begin
                s_axi_rdata[CAL_READY_BIT]         <= ready_s2;
                s_axi_rdata[CAL_PSAVE_BIT]         <= psave_q;
                s_axi_rdata[CAL_LOCK_BIT]          <= lock_q;
                s_axi_rdata[CAL_PDN_BIT]           <= pdn_q;
                s_axi_rdata[CAL_DRIVE_LSB +: 3]    <= drive_strength;
                s_axi_rdata[CAL_FILTER_LSB +: 3]   <= filter_setting;
            end
            else if (addr_is(s_axi_araddr, PAD_CFG_ADDR))
            begin
                s_axi_rdata[CFG_TERM_ON_LSB +: 2]  <= CODE_ZERO;
                s_axi_rdata[CFG_TERM_OFF_LSB +: 2] <= CODE_ZERO;
                s_axi_rdata[CFG_PD_BIT]            <= pd_en;
                s_axi_rdata[CFG_RX_BIT]            <= rx_sel;
                s_axi_rdata[CFG_DSLEW_LSB +: 2]    <= CODE_ZERO;
                s_axi_rdata[CFG_CSLEW_LSB +: 2]    <= CODE_ZERO;
            end
            else if (addr_is(s_axi_araddr, FUSE_SHADOW_ADDR))
            begin
                s_axi_rdata[1:0] <= fuse_shadow_bits;
            end
            else
            begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- bench/pad_ctrl_regs_props.sv ----
`timescale 1ns/1ps
module pad_ctrl_regs_props
    import pad_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Bus handshakes
    input wire logic              s_axi_awready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    // Pad controls
    input wire logic              impedance_lock,
    input wire logic              calibrator_shutdown,
    input wire logic              resistor_power_save,
    input wire logic [2:0]        drive_strength,
    input wire logic [2:0]        filter_setting
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_done; $rose(s_axi_bvalid); endsequence
    sequence s_rd_go; s_axi_arvalid && s_axi_arready; endsequence
    property p_lock; $changed(impedance_lock) |-> s_wr_done; endproperty
    property p_pdn; $changed(calibrator_shutdown) |-> s_wr_done; endproperty
    property p_trim;
        $changed({drive_strength, filter_setting}) |-> s_wr_done;
    endproperty
    property p_psave; calibrator_shutdown |-> !resistor_power_save; endproperty
    property p_rd_ans; s_rd_go |=> s_axi_rvalid; endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_wr_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_lock: assert property (p_lock)
        else $error("lock moved without a write");
    a_pdn: assert property (p_pdn)
        else $error("shutdown moved without a write");
    a_trim: assert property (p_trim)
        else $error("trim moved without a write");
    a_psave: assert property (p_psave)
        else $error("power save while shut down");
    a_rd_ans: assert property (p_rd_ans)
        else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data not held");
    a_wr_hold: assert property (p_wr_hold)
        else $error("write response dropped");
    a_wr_busy: assert property (p_wr_busy)
        else $error("address taken while busy");
endmodule
bind pad_ctrl_regs pad_ctrl_regs_props i_props (.*);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import pad_ctrl_pkg::*;
;
    logic              aclk;
    logic              aresetn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0;
    logic [3:0]        s_axi_wstrb = '0;
    logic              s_axi_awvalid = 1'h0;
    logic              s_axi_wvalid = 1'h0;
    logic              s_axi_bready = 1'h0;
    logic              s_axi_arvalid = 1'h0;
    logic              s_axi_rready = 1'h0;
    logic              fuse_receiver_type = 1'h1;
    logic              fuse_pulldown = 1'h0;
    logic              calibration_ready = 1'h0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [DATA_W-1:0] s_axi_rdata;
    logic              impedance_lock, calibrator_shutdown;
    logic              resistor_power_save, receiver_type_select;
    logic              pad_pulldown_enable;
    logic [2:0]        drive_strength, filter_setting;
    int                failures = 0;
    int                num_checks = 0;
    wire  [10:0]       outs = {impedance_lock, calibrator_shutdown,
        resistor_power_save, drive_strength, filter_setting,
        receiver_type_select, pad_pulldown_enable};

    pad_ctrl_regs i_dut (.*);

    initial
    begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    task automatic test_done();
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Bus write, waits for the response
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'h0;
        chk("bresp", er, s_axi_bresp);
        @(posedge aclk);
    endtask

    // Bus read, compares data and response
    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'h0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        @(posedge aclk);
    endtask

    task automatic t_reset();
        rd(CAL_CTRL_ADDR, 32'h77, RESP_OKAY);
        rd(PAD_CFG_ADDR, 32'h10, RESP_OKAY);
        rd(FUSE_SHADOW_ADDR, 32'h1, RESP_OKAY);
        chk("outputs", {3'h2, 3'h6, 3'h7, 2'h2}, outs);
    endtask

    task automatic t_cal();
        wr(CAL_CTRL_ADDR, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(CAL_CTRL_ADDR, 32'h1FF, RESP_OKAY);
        chk("outputs", {3'h6, 3'h7, 3'h7, 2'h2}, outs);
        wr(CAL_CTRL_ADDR, 32'h1AA, 4'hF, RESP_OKAY);
        chk("outputs", {3'h5, 3'h5, 3'h2, 2'h2}, outs);
        wr(CAL_CTRL_ADDR, 32'h0, 4'h2, RESP_OKAY);
        rd(CAL_CTRL_ADDR, 32'hAA, RESP_OKAY);
        chk("outputs", {3'h4, 3'h5, 3'h2, 2'h2}, outs);
    endtask

    task automatic t_cfg();
        wr(PAD_CFG_ADDR, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(PAD_CFG_ADDR, 32'h30, RESP_OKAY);
        wr(PAD_CFG_ADDR, 32'hF2F, 4'h3, RESP_OKAY);
        rd(PAD_CFG_ADDR, 32'h20, RESP_OKAY);
        chk("outputs", {3'h4, 3'h5, 3'h2, 2'h1}, outs);
        wr(PAD_CFG_ADDR, 32'h10, 4'h2, RESP_OKAY);
        rd(PAD_CFG_ADDR, 32'h20, RESP_OKAY);
    endtask

    task automatic t_bad();
        wr(12'h00C, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
        rd(12'h00C, 32'h0, RESP_SLVERR);
        rd(PAD_CFG_ADDR, 32'h20, RESP_OKAY);
    endtask

    task automatic t_rst2();
        calibration_ready <= 1'h1;
        fuse_pulldown <= 1'h1;
        fuse_receiver_type <= 1'h0;
        repeat (4) @(posedge aclk);
        rd(CAL_CTRL_ADDR, 32'h80AA, RESP_OKAY);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
        rd(CAL_CTRL_ADDR, 32'h8077, RESP_OKAY);
        rd(PAD_CFG_ADDR, 32'h20, RESP_OKAY);
        chk("outputs", {3'h2, 3'h6, 3'h7, 2'h1}, outs);
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
        t_reset();
        t_cal();
        t_cfg();
        t_bad();
        t_rst2();
        test_done();
    end

    initial
    begin
        repeat (4000) @(posedge aclk);
        failures++;
        test_done();
    end
endmodule
